/* File: hw/charge_time_measure_control.v */
// Control logic of the charge time unit: registers, edge handling, outputs
// Assumes a register port with one-cycle strobes and read data next cycle
`timescale 1ns/100ps
`default_nettype none
`include "charge_time_consts.vh"

// What this block does
// - Idle-stop bit 13 halts the unit while the device idles.
// - Bit 11 picks hardware edge sources, else software sets edge flags.
// - Bit 10 accepts edge 2 only after edge 1 occurred, or in the same software write as edge 1.
// - Bit 9 grounds the current source and closes channel 0 switch.
// - Bit 8 lets the unit trigger converter start of conversion.
// - Control bits 14 and 7..0 read zero, writes ignored.
module charge_time_measure_control
#(
    parameter TRIG_CYCLES = `TRIG_PULSE_CYCLES
)
(
    input  wire        ref_clk,
    input  wire        reset,
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [15:0] regRdData,
    input  wire        deviceIdle,
    input  wire        hwEdge1,
    input  wire        hwEdge2,
    output wire        unitActive,
    output wire        delayGenActive,
    output wire        currentSourceOn,
    output wire        sourceGrounded,
    output wire        channelZeroSwitch,
    output wire        converterTrigger,
    output wire [5:0]  currentTrim,
    output wire [1:0]  currentRange,
    output wire        edge1Status,
    output wire        edge2Status
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [15:0] control_q;
    reg  [15:0] trimRange_q;
    wire        wrCtrl;
    wire        wrTrim;
    wire        wrEdge;
    wire        unitEnable;
    wire        idleStop;
    wire        delayGenEnable;
    wire        hwEdgeSelect;
    wire        edgeOrderEnable;
    wire        sourceDischarge;
    wire        triggerEnable;
    wire        running;
    wire        edge1Set;
    wire        edge2Set;
    wire        sw1Set;
    wire        sw2Set;
    wire        bothDone;
    reg         bothDone_q;
    wire        convStart;

    assign wrCtrl = regWrite && (regAddr == `ADDR_MEASURE_CONTROL_ONE);
    assign wrTrim = regWrite && (regAddr == `ADDR_CURRENT_TRIM_RANGE);
    assign wrEdge = regWrite && (regAddr == `ADDR_EDGE_STATUS);

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            control_q   <= `CTRL_RESET;
            trimRange_q <= `TRIM_RANGE_RESET;
        end
        else
        begin
            if (wrCtrl)
                control_q <= regWrData & `CTRL_WRITE_MASK;
            if (wrTrim)
                trimRange_q <= regWrData & `TRIM_RANGE_WRITE_MASK;
        end
    end

    assign unitEnable      = control_q[`BIT_UNIT_ENABLE];
    assign idleStop        = control_q[`BIT_IDLE_STOP];
    assign delayGenEnable  = control_q[`BIT_DELAY_GEN_ENABLE];
    assign hwEdgeSelect    = control_q[`BIT_HW_EDGE_SELECT];
    assign edgeOrderEnable = control_q[`BIT_EDGE_ORDER_ENABLE];
    assign sourceDischarge = control_q[`BIT_SOURCE_DISCHARGE];
    assign triggerEnable   = control_q[`BIT_CONVERTER_TRIGGER];

    // ------------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------------
    assign running = unitEnable && !(idleStop && deviceIdle);

    assign unitActive      = running;
    assign delayGenActive  = running && delayGenEnable;
    assign currentSourceOn = running && !sourceDischarge;
    assign sourceGrounded    = sourceDischarge;
    assign channelZeroSwitch = sourceDischarge;
    assign currentTrim  = trimRange_q[`TRIM_MSB:`TRIM_LSB];
    assign currentRange = trimRange_q[`RANGE_MSB:`RANGE_LSB];

    // ------------------------------------------------------------------
    // Edge flags
    // ------------------------------------------------------------------
    assign sw1Set = wrEdge && regWrData[`BIT_EDGE1_STATUS];
    assign sw2Set = wrEdge && regWrData[`BIT_EDGE2_STATUS];

    // Hardware sources only in hardware mode; software write sets otherwise
    assign edge1Set = running && (hwEdgeSelect ? hwEdge1 : 1'b0);
    assign edge2Set = running && (hwEdgeSelect ? hwEdge2 : 1'b0)
                      && (!edgeOrderEnable || edge1Status);

    edge_latch edge1Latch
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .setPulse(edge1Set),
        .swWrite (wrEdge && (running || !sw1Set)),
        .swValue (sw1Set && !hwEdgeSelect),
        .flag_q  (edge1Status)
    );

    edge_latch edge2Latch
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .setPulse(edge2Set),
        .swWrite (wrEdge && (running || !sw2Set)),
        .swValue (sw2Set && !hwEdgeSelect
                  && (!edgeOrderEnable || edge1Status || sw1Set)),
        .flag_q  (edge2Status)
    );

    // ------------------------------------------------------------------
    // Converter trigger on completion of both edges
    // ------------------------------------------------------------------
    assign bothDone = edge1Status && edge2Status;

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            bothDone_q <= 1'b0;
        else
            bothDone_q <= bothDone;
    end

    assign convStart = running && triggerEnable && bothDone && !bothDone_q;

    trigger_pulse #(.WIDTH(TRIG_CYCLES)) convTrig
    (
        .ref_clk(ref_clk),
        .reset  (reset),
        .start  (convStart),
        .pulse_q(converterTrigger)
    );

    // ------------------------------------------------------------------
    // Read port, data the cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            regRdData <= 16'h0000;
        else if (regRead)
        begin
            case (regAddr)
                `ADDR_MEASURE_CONTROL_ONE: regRdData <= control_q;
                `ADDR_CURRENT_TRIM_RANGE:  regRdData <= trimRange_q;
                `ADDR_EDGE_STATUS:
                    regRdData <= {14'h0000, edge2Status, edge1Status};
                default:                   regRdData <= 16'h0000;
            endcase
        end
        else
            regRdData <= 16'h0000;
    end

endmodule

`default_nettype wire

/* File: hw/charge_time_consts.vh */
// Constants for the charge time unit control block: offsets, fields, resets
// Assumes a 16-bit register port and a 125 MHz ref_clk
`ifndef CHARGE_TIME_CONSTS_VH
`define CHARGE_TIME_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_MEASURE_CONTROL_ONE  4'h0
`define ADDR_CURRENT_TRIM_RANGE   4'h1
`define ADDR_EDGE_STATUS          4'h2
`define ADDR_WIDTH                4

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define BIT_UNIT_ENABLE           15
`define BIT_IDLE_STOP             13
`define BIT_DELAY_GEN_ENABLE      12
`define BIT_HW_EDGE_SELECT        11
`define BIT_EDGE_ORDER_ENABLE     10
`define BIT_SOURCE_DISCHARGE      9
`define BIT_CONVERTER_TRIGGER     8
`define CTRL_WRITE_MASK           16'hbf00
`define CTRL_RESET                16'h0000

// ----------------------------------------------------------------------
// Trim and range register fields
// ----------------------------------------------------------------------
`define TRIM_MSB                  15
`define TRIM_LSB                  10
`define RANGE_MSB                 9
`define RANGE_LSB                 8
`define TRIM_RANGE_WRITE_MASK     16'hff00
`define TRIM_RANGE_RESET          16'h0000

// ----------------------------------------------------------------------
// Edge status register fields
// ----------------------------------------------------------------------
`define BIT_EDGE1_STATUS          0
`define BIT_EDGE2_STATUS          1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS             8
`define TRIG_PULSE_NS             16
`define TRIG_PULSE_CYCLES         ((`TRIG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: hw/edge_latch.v */
// One edge status flag: set by hardware or software, cleared by software
// Assumes pulse inputs synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module edge_latch
(
    input  wire ref_clk,
    input  wire reset,
    input  wire setPulse,
    input  wire swWrite,
    input  wire swValue,
    output reg  flag_q
);

    reg flag_d;

    // ------------------------------------------------------------------
    // Set wins over a clear in the same cycle
    // ------------------------------------------------------------------
    always @*
    begin
        flag_d = flag_q;
        if (swWrite)
            flag_d = swValue;
        if (setPulse)
            flag_d = 1'b1;
    end

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

endmodule

`default_nettype wire

/* File: hw/trigger_pulse.v */
// Stretches a start event into a conversion trigger pulse of fixed length
// Assumes events synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module trigger_pulse
#(
    parameter WIDTH = 2
)
(
    input  wire ref_clk,
    input  wire reset,
    input  wire start,
    output reg  pulse_q
);

    reg [3:0] count_q;

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            count_q <= 4'h0;
            pulse_q <= 1'b0;
        end
        else if (start)
        begin
            count_q <= WIDTH[3:0] - 4'h1;
            pulse_q <= 1'b1;
        end
        else if (count_q != 4'h0)
            count_q <= count_q - 4'h1;
        else
            pulse_q <= 1'b0;
    end

endmodule

`default_nettype wire

/* File: testbench/edge_source_model.sv */
// Partner model: hardware edge sources and the analog converter
// Assumes it shares ref_clk with the block; pulses start after an edge
`timescale 1ns/100ps
`default_nettype none
module edge_source_model
(
    input  wire logic ref_clk,
    input  wire logic converterTrigger,
    input  wire logic sourceGrounded,
    output var  logic hwEdge1,
    output var  logic hwEdge2,
    output wire logic sampling,
    output var  int   trigCount
);
    initial
    begin
        hwEdge1 = 1'b0;
        hwEdge2 = 1'b0;
        trigCount = 0;
    end
    // Converter stays in sampling while the discharge sink is on
    assign sampling = sourceGrounded;
    always @(posedge converterTrigger)
        trigCount <= trigCount + 1;
    task pulse(input int n);
        @(posedge ref_clk);
        hwEdge1 <= (n == 1);
        hwEdge2 <= (n == 2);
        @(posedge ref_clk);
        hwEdge1 <= 1'b0;
        hwEdge2 <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/charge_time_measure_control_checker.sv */
// Assertions on the ports of the charge time control block
// Assumes binding into charge_time_measure_control, default TRIG_CYCLES
`timescale 1ns/100ps
`default_nettype none
module charge_time_measure_control_checker
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [3:0]  regAddr,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [15:0] regRdData,
    input wire logic        unitActive,
    input wire logic        delayGenActive,
    input wire logic        currentSourceOn,
    input wire logic        sourceGrounded,
    input wire logic        channelZeroSwitch,
    input wire logic        converterTrigger,
    input wire logic [5:0]  currentTrim,
    input wire logic [1:0]  currentRange,
    input wire logic        edge1Status,
    input wire logic        edge2Status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    AST_DELAY_NEEDS_UNIT: assert property (
        delayGenActive |-> unitActive) else $error("delay gen while off");
    AST_SOURCE_NEEDS_UNIT: assert property (
        currentSourceOn |-> unitActive) else $error("source on while off");
    AST_SWITCH_FOLLOWS: assert property (
        sourceGrounded == channelZeroSwitch) else $error("switch mismatch");
    AST_GROUND_STOPS: assert property (
        sourceGrounded |-> !currentSourceOn) else $error("grounded source on");
    AST_TRIG_CAUSE: assert property (
        $rose(converterTrigger) |-> edge1Status && edge2Status
        ##0 converterTrigger[*2] ##1 !converterTrigger)
        else $error("trigger pulse wrong");
    AST_FLAG_NEEDS_UNIT: assert property (
        $rose(edge1Status) |-> $past(unitActive)) else $error("flag set off");
    AST_CTRL_UNUSED_ZERO: assert property (
        regRead && regAddr == 4'h0 |=> regRdData[14] == 1'b0
        && regRdData[7:0] == 8'h00) else $error("unused bits not zero");
    AST_TRIM_READBACK: assert property (
        regRead && regAddr == 4'h1 |=> regRdData ==
        {$past(currentTrim), $past(currentRange), 8'h00})
        else $error("trim readback wrong");
    AST_TRIM_STEADY: assert property (
        !$past(regWrite) |-> $stable({currentTrim, currentRange}))
        else $error("trim changed without write");
    AST_IDLE_DATA_ZERO: assert property (
        !regRead |=> regRdData == 16'h0000) else $error("stale read data");
    cover property ($rose(converterTrigger));
    cover property (sourceGrounded && unitActive);
    cover property ($rose(edge2Status));
endmodule
bind charge_time_measure_control charge_time_measure_control_checker
    charge_time_measure_control_checker_inst (.ref_clk, .reset, .regAddr,
    .regRead, .regWrite, .regRdData, .unitActive, .delayGenActive,
    .currentSourceOn, .sourceGrounded, .channelZeroSwitch,
    .converterTrigger, .currentTrim, .currentRange, .edge1Status,
    .edge2Status);
`default_nettype wire

/* File: testbench/charge_time_measure_control_test.sv */
// Self-checking bench for the charge time control block
// Assumes default TRIG_CYCLES and the partner model of the edge sources
`timescale 1ns/100ps
`default_nettype none
module charge_time_measure_control_test;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrite;
    logic        regRead;
    logic        deviceIdle;
    wire  logic  sampling;
    wire  logic [15:0] regRdData;
    wire  logic [5:0]  currentTrim;
    wire  logic [1:0]  currentRange;
    wire  logic  unitActive, delayGenActive, currentSourceOn, sourceGrounded;
    wire  logic  channelZeroSwitch, converterTrigger, edge1Status;
    wire  logic  edge2Status, hwEdge1, hwEdge2;
    int          trigCount;
    int          err_count = 0;
    int          num_checks = 0;
    logic [15:0] ctlTab [8] = '{16'h8000, 16'h9000, 16'h8200, 16'h0200,
                                16'ha000, 16'ha000, 16'h8000, 16'h0000};
    logic [7:0]  idleTab = 8'b0101_1000;
    logic [4:0]  outTab [8] = '{5'h14, 5'h1c, 5'h13, 5'h03,
                                5'h00, 5'h14, 5'h14, 5'h00};
    always #4 ref_clk = ~ref_clk;
    charge_time_measure_control charge_time_measure_control_inst (.ref_clk,
        .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .deviceIdle, .hwEdge1, .hwEdge2, .unitActive, .delayGenActive,
        .currentSourceOn, .sourceGrounded, .channelZeroSwitch,
        .converterTrigger, .currentTrim, .currentRange, .edge1Status,
        .edge2Status);
    edge_source_model edge_source_model_inst (.ref_clk, .converterTrigger,
        .sourceGrounded, .hwEdge1, .hwEdge2, .sampling(sampling), .trigCount);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        regAddr <= 4'h0;
        regWrData <= 16'h0000;
        regWrite <= 1'b0;
        regRead <= 1'b0;
        deviceIdle <= 1'b0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0000);
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'hbf00);
        wr(4'h1, 16'ha5ff);
        rd(4'h1, 16'ha500);
        chk({8'h00, currentTrim, currentRange}, 16'h00a5);
        rd(4'h3, 16'h0000);
        $display("register test done");
        for (int i = 0; i < 8; i++)
        begin
            deviceIdle <= idleTab[7 - i];
            wr(4'h0, ctlTab[i]);
            chk({11'h000, unitActive, delayGenActive, currentSourceOn,
                 sourceGrounded, channelZeroSwitch}, {11'h000, outTab[i]});
        end
        $display("output test done");
        wr(4'h0, 16'h8300);
        chk({15'h0000, sampling}, 16'h0001);
        wr(4'h0, 16'h8100);
        wr(4'h2, 16'h0003);
        rd(4'h2, 16'h0003);
        repeat (3) @(posedge ref_clk);
        chk(16'(trigCount), 16'h0001);
        wr(4'h2, 16'h0000);
        edge_source_model_inst.pulse(1);
        rd(4'h2, 16'h0000);
        $display("software edge test done");
        wr(4'h0, 16'h8d00);
        wr(4'h2, 16'h0003);
        rd(4'h2, 16'h0000);
        edge_source_model_inst.pulse(2);
        rd(4'h2, 16'h0000);
        edge_source_model_inst.pulse(1);
        rd(4'h2, 16'h0001);
        edge_source_model_inst.pulse(2);
        rd(4'h2, 16'h0003);
        repeat (3) @(posedge ref_clk);
        chk(16'(trigCount), 16'h0002);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h8800);
        edge_source_model_inst.pulse(2);
        rd(4'h2, 16'h0002);
        edge_source_model_inst.pulse(1);
        repeat (3) @(posedge ref_clk);
        chk(16'(trigCount), 16'h0002);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h0800);
        edge_source_model_inst.pulse(1);
        rd(4'h2, 16'h0000);
        $display("hardware edge test done");
        conclude();
    end
endmodule
`default_nettype wire
